// *** logic/dcc_pkg.sv ***
// Package of constants and types for the dual comparator control block.
// Assumes one 20 MHz clock and a plain address/strobe register port.
package dcc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK   = 4'h2;

  localparam int BIT_CMP2_RESULT = 7;
  localparam int BIT_CMP1_RESULT = 6;
  localparam int BIT_CMP2_POL    = 5;
  localparam int BIT_CMP1_POL    = 4;
  localparam int BIT_SWAP        = 3;
  localparam int BIT_MODE_HI     = 2;
  localparam int BIT_CHANGE      = 0;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;

  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    MODE_RESET      = 3'b000,
    MODE_ONE        = 3'b001,
    MODE_TWO_INDEP  = 3'b010,
    MODE_COMMON_REF = 3'b011,
    MODE_INDEP_OUT  = 3'b100,
    MODE_COMMON_OUT = 3'b101,
    MODE_MUX_VREF   = 3'b110,
    MODE_OFF        = 3'b111
  } dcc_mode_t;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_PIN1 = 3'b001,
    SRC_PIN2 = 3'b010,
    SRC_PIN3 = 3'b011,
    SRC_PIN4 = 3'b100,
    SRC_PIN5 = 3'b101,
    SRC_PIN6 = 3'b110,
    SRC_VREF = 3'b111
  } dcc_src_t;

  typedef struct packed {
    logic     powered;
    dcc_src_t pos_sel;
    dcc_src_t neg_sel;
    logic     to_pin;
  } dcc_route_t;

endpackage

// *** logic/dcc_sync.sv ***
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs and an already synchronised active-low reset.
`timescale 1ns/1ps
module dcc_sync
  import dcc_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic [SYNC_STAGES-1:0] stage_r;
      logic [SYNC_STAGES-1:0] stage_nxt;
      logic                   held_r;
      logic                   held_nxt;

      // A change is taken only once stages two and three agree.
      always_comb begin
        stage_nxt = {stage_r[SYNC_STAGES-2:0], din[g]};
        held_nxt  = (stage_r[1] == stage_r[2]) ? stage_r[2] : held_r;
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage_r <= '0;
          held_r  <= 1'b0;
        end else begin
          stage_r <= stage_nxt;
          held_r  <= held_nxt;
        end
      end

      assign dout[g] = held_r;
    end
  endgenerate

endmodule

// *** logic/dcc_top.sv ***
// Control and status logic around two analog comparators.
// Assumes the analog cores give a digital result each and take route selects.
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RESET_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  input  wire logic              CMP1_RAW,
  input  wire logic              CMP2_RAW,
  output dcc_route_t             CMP1_ROUTE,
  output dcc_route_t             CMP2_ROUTE,
  output logic      [1:0]        PIN_OUT,
  output logic      [1:0]        PIN_OUT_SEL,
  output logic                   IRQ
);

  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Routing of one channel for a given mode; index 0 is comparator 1.
  function automatic dcc_route_t route_of(input dcc_mode_t m,
                                          input logic      sw,
                                          input logic      second);
    dcc_route_t r;
    r = '0;
    case (m)
      MODE_ONE: begin
        r.powered = !second;
        r.pos_sel = second ? SRC_NONE : SRC_PIN5;
        r.neg_sel = second ? SRC_NONE : SRC_PIN6;
      end
      MODE_TWO_INDEP, MODE_INDEP_OUT: begin
        r.powered = 1'b1;
        r.pos_sel = second ? SRC_PIN3 : SRC_PIN5;
        r.neg_sel = second ? SRC_PIN4 : SRC_PIN6;
        r.to_pin  = (m == MODE_INDEP_OUT);
      end
      MODE_COMMON_REF, MODE_COMMON_OUT: begin
        r.powered = 1'b1;
        r.pos_sel = SRC_PIN5;
        r.neg_sel = second ? SRC_PIN4 : SRC_PIN6;
        r.to_pin  = (m == MODE_COMMON_OUT);
      end
      MODE_MUX_VREF: begin
        r.powered = 1'b1;
        r.pos_sel = SRC_VREF;
        if (sw) begin
          r.neg_sel = second ? SRC_PIN3 : SRC_PIN5;
        end else begin
          r.neg_sel = second ? SRC_PIN4 : SRC_PIN6;
        end
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  logic [1:0] raw_s;

  dcc_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .din   ({CMP2_RAW, CMP1_RAW}),
    .dout  (raw_s)
  );

  logic       ctrl_wr;
  logic       ctrl_acc;
  logic       stat_wr;
  logic       mask_wr;

  assign ctrl_wr  = WR && (ADDR == ADDR_CTRL);
  assign ctrl_acc = (WR || RD) && (ADDR == ADDR_CTRL);
  assign stat_wr  = WR && (ADDR == ADDR_STATUS);
  assign mask_wr  = WR && (ADDR == ADDR_MASK);

  // Control register.
  dcc_mode_t  mode_r;
  dcc_mode_t  mode_nxt;
  logic       swap_r;
  logic       swap_nxt;
  logic [1:0] pol_r;
  logic [1:0] pol_nxt;

  always_comb begin
    mode_nxt = mode_r;
    swap_nxt = swap_r;
    pol_nxt  = pol_r;
    if (ctrl_wr) begin
      mode_nxt = dcc_mode_t'(WDATA[BIT_MODE_HI:0]);
      swap_nxt = WDATA[BIT_SWAP];
      pol_nxt  = {WDATA[BIT_CMP2_POL], WDATA[BIT_CMP1_POL]};
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= dcc_mode_t'(CTRL_RESET[BIT_MODE_HI:0]);
      swap_r <= CTRL_RESET[BIT_SWAP];
      pol_r  <= {CTRL_RESET[BIT_CMP2_POL], CTRL_RESET[BIT_CMP1_POL]};
    end else begin
      mode_r <= mode_nxt;
      swap_r <= swap_nxt;
      pol_r  <= pol_nxt;
    end
  end

  // Results, routing and pin drive of the two channels.
  dcc_route_t route_nxt [2];
  logic [1:0] pwr;
  logic [1:0] result_r;
  logic [1:0] result_nxt;
  logic [1:0] pin_out_nxt;
  logic [1:0] pin_sel_nxt;

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      always_comb begin
        route_nxt[c] = route_of(mode_r, swap_r, c == 1);
        pwr[c]       = (c == 0) ? CMP1_ROUTE.powered : CMP2_ROUTE.powered;
        // A powered-down core reads as low before polarity is applied.
        result_nxt[c]  = (pwr[c] & raw_s[c]) ^ pol_r[c];
        pin_out_nxt[c] = result_nxt[c];
        pin_sel_nxt[c] = route_nxt[c].to_pin;
      end
    end
  endgenerate

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      CMP1_ROUTE  <= '0;
      CMP2_ROUTE  <= '0;
      result_r    <= 2'h0;
      PIN_OUT     <= 2'h0;
      PIN_OUT_SEL <= 2'h0;
    end else begin
      CMP1_ROUTE  <= route_nxt[0];
      CMP2_ROUTE  <= route_nxt[1];
      result_r    <= result_nxt;
      PIN_OUT     <= pin_out_nxt;
      PIN_OUT_SEL <= pin_sel_nxt;
    end
  end

  // Change detection, status, mask and interrupt.
  logic [1:0] last_r;
  logic [1:0] last_nxt;
  logic       flag_r;
  logic       flag_nxt;
  logic       mask_r;
  logic       mask_nxt;
  logic       irq_nxt;
  logic       mismatch;

  assign mismatch = (result_r != last_r);

  always_comb begin
    last_nxt = ctrl_acc ? result_r : last_r;
    flag_nxt = flag_r;
    if (stat_wr && WDATA[BIT_CHANGE]) begin
      flag_nxt = 1'b0;
    end
    // A pending mismatch sets the flag even in a clearing cycle.
    if (mismatch) begin
      flag_nxt = 1'b1;
    end
    mask_nxt = mask_wr ? WDATA[BIT_CHANGE] : mask_r;
    irq_nxt  = flag_r & mask_r;
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      last_r <= 2'h0;
      flag_r <= STATUS_RESET[BIT_CHANGE];
      mask_r <= MASK_RESET[BIT_CHANGE];
      IRQ    <= 1'b0;
    end else begin
      last_r <= last_nxt;
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
      IRQ    <= irq_nxt;
    end
  end

  // Read port.
  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = '0;
    if (RD) begin
      case (ADDR)
        ADDR_CTRL: begin
          rdata_nxt[BIT_CMP2_RESULT] = result_r[1];
          rdata_nxt[BIT_CMP1_RESULT] = result_r[0];
          rdata_nxt[BIT_CMP2_POL]    = pol_r[1];
          rdata_nxt[BIT_CMP1_POL]    = pol_r[0];
          rdata_nxt[BIT_SWAP]        = swap_r;
          rdata_nxt[BIT_MODE_HI:0]   = mode_r;
        end
        ADDR_STATUS: begin
          rdata_nxt[BIT_CHANGE] = flag_r;
        end
        ADDR_MASK: begin
          rdata_nxt[BIT_CHANGE] = mask_r;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= '0;
    end else begin
      RDATA <= rdata_nxt;
    end
  end

  AST_POLARITY_SET: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (pwr[0] && raw_s[0] && pol_r[0]) |=> !result_r[0])
    else $error("Inverted comparator 1 result not low.");

  AST_POLARITY_CLEAR: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (pwr[1] && raw_s[1] && !pol_r[1]) |=> result_r[1])
    else $error("Comparator 2 result not high for a high core.");

  AST_VREF_MODE: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (mode_r == MODE_MUX_VREF) |=>
      (CMP1_ROUTE.pos_sel == SRC_VREF) && (CMP2_ROUTE.pos_sel == SRC_VREF))
    else $error("Reference not routed to both non-inverting inputs.");

  AST_SWAP_PAIRS: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (mode_r == MODE_MUX_VREF && swap_r) |=>
      (CMP1_ROUTE.neg_sel == SRC_PIN5) && (CMP2_ROUTE.neg_sel == SRC_PIN3))
    else $error("Swapped inverting inputs not on the second pin pair.");

  AST_RESET_MODE: assert property (@(posedge CLOCK)
    $rose(rst_n) |-> (mode_r == MODE_RESET) && !CMP1_ROUTE.powered
      && !CMP2_ROUTE.powered && (pol_r == 2'h0))
    else $error("Reset did not leave the comparators in reset mode.");

  AST_CTRL_WRITE: assert property (@(posedge CLOCK) disable iff (!rst_n)
    ctrl_wr |=> (mode_r == $past(WDATA[2:0])) ##1
      (CMP2_ROUTE.powered == ($past(mode_r) inside {MODE_TWO_INDEP,
        MODE_COMMON_REF, MODE_INDEP_OUT, MODE_COMMON_OUT, MODE_MUX_VREF})))
    else $error("Control write did not reach the routing.");

  AST_FLAG_SET: assert property (@(posedge CLOCK) disable iff (!rst_n)
    mismatch |=> flag_r ##1 (IRQ == $past(mask_r)))
    else $error("Mismatch did not set the change flag.");

  AST_READ_ENDS: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD && ADDR == ADDR_CTRL) |=> (last_r == $past(result_r)))
    else $error("Control read did not end the mismatch.");

  AST_READ_DATA: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (RD && ADDR == ADDR_CTRL) |=>
      (RDATA[7:6] == $past(result_r)) && (RDATA[2:0] == $past(mode_r)))
    else $error("Control read data out of place.");

  AST_OFF_MODES: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (mode_r == MODE_OFF || mode_r == MODE_RESET) |=>
      !CMP1_ROUTE.powered && !CMP2_ROUTE.powered)
    else $error("Comparator powered in an off mode.");

  AST_FLAG_CLEAR: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (stat_wr && WDATA[BIT_CHANGE] && !mismatch) |=> !flag_r)
    else $error("Change flag not cleared by a written one.");

  AST_IRQ_MASKED: assert property (@(posedge CLOCK) disable iff (!rst_n)
    !mask_r |=> !IRQ)
    else $error("Interrupt raised while masked.");

  AST_PIN_ROUTE: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (mode_r == MODE_INDEP_OUT || mode_r == MODE_COMMON_OUT) |=>
      (PIN_OUT_SEL == 2'h3))
    else $error("Results not routed to the output pins.");

  AST_MODE_ONE: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (mode_r == MODE_ONE) |=> CMP1_ROUTE.powered && !CMP2_ROUTE.powered)
    else $error("Single comparator mode powers the wrong cores.");

endmodule

// *** verif/dcc_ana_model.sv ***
// Behavioural model of one analog comparator core and its input multiplexer.
// Assumes the bench supplies pin and reference levels as 8-bit codes.
`timescale 1ns/1ps
module dcc_ana_model
  import dcc_pkg::*;
(
  input  wire dcc_route_t      route,
  input  wire logic [7:0][7:0] volts,
  output logic                 raw
);
  // Index 7 holds the internal reference and 1 to 6 the shared pins.
  always_comb begin
    if (route.powered) begin
      raw = volts[route.pos_sel] > volts[route.neg_sel];
    end else begin
      raw = 1'b0;
    end
  end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the dual comparator control block.
// Assumes the analog cores are stood in for by the behavioural model.
`timescale 1ns/1ps
module tb;
  import dcc_pkg::*;
  logic            CLOCK   = 1'b0;
  logic            RESET_N = 1'b0;
  logic [3:0]      ADDR    = 4'h0;
  logic [7:0]      WDATA   = 8'h00;
  logic            WR      = 1'b0;
  logic            RD      = 1'b0;
  logic [7:0]      RDATA;
  logic            raw1;
  logic            raw2;
  dcc_route_t      route1;
  dcc_route_t      route2;
  logic [1:0]      pin_out;
  logic [1:0]      pin_sel;
  logic            IRQ;
  logic [7:0][7:0] volts = '0;
  logic [7:0]      rd_v;
  logic [31:0]     seed = 32'd81843;
  int              n_fail;
  int              check_count;
  int              cyc;
  dcc_route_t      er;

  always #25 CLOCK = ~CLOCK;

  dcc_top dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CMP1_RAW(raw1), .CMP2_RAW(raw2),
    .CMP1_ROUTE(route1), .CMP2_ROUTE(route2), .PIN_OUT(pin_out),
    .PIN_OUT_SEL(pin_sel), .IRQ(IRQ));
  dcc_ana_model ana1 (.route(route1), .volts(volts), .raw(raw1));
  dcc_ana_model ana2 (.route(route2), .volts(volts), .raw(raw2));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Expected routing of one comparator, from the mode table.
  function automatic dcc_route_t exp_route(input int n, input int m,
                                           input bit sw);
    dcc_route_t r;
    r = '0;
    r.powered = (m >= 1 && m <= 6 && (n == 1 || m != 1));
    if (r.powered) begin
      r.pos_sel = (m == 6) ? SRC_VREF : (n == 2 && (m == 2 || m == 4))
                  ? SRC_PIN3 : SRC_PIN5;
      if (m == 6 && sw) r.neg_sel = (n == 1) ? SRC_PIN5 : SRC_PIN3;
      else r.neg_sel = (n == 1) ? SRC_PIN6 : SRC_PIN4;
      r.to_pin = (m == 4 || m == 5);
    end
    return r;
  endfunction

  function automatic logic exp_res(input dcc_route_t r, input logic pol);
    if (!r.powered) return pol;
    return (volts[r.pos_sel] > volts[r.neg_sel]) ^ pol;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLOCK);
    WR    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLOCK);
    RD   <= 1'b0;
    #1;
    d = RDATA;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask

  task automatic close_out();
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    logic [7:0] c;
    logic [1:0] pol;
    logic [1:0] res;
    repeat (3) @(posedge CLOCK);
    RESET_N <= 1'b1;
    settle(5);
    for (int a = 0; a < 4; a++) begin
      rd(a[3:0], rd_v);
      chk(rd_v, 8'h00);
    end
    for (int i = 0; i < 48; i++) begin
      seed = xs(seed);
      pol  = seed[1:0];
      for (int p = 1; p < 8; p++) volts[p] = {seed[p+8 +: 5], p[2:0]};
      c = {seed[3:2], pol, i[3], i[2:0]};
      wr(ADDR_CTRL, c);
      settle(10);
      er = exp_route(1, i % 8, i[3]);
      chk(route1, er);
      res[0] = exp_res(er, pol[0]);
      chk({6'h0, pin_sel}, {6'h0, {2{er.to_pin}}});
      er = exp_route(2, i % 8, i[3]);
      chk(route2, er);
      res[1] = exp_res(er, pol[1]);
      rd(ADDR_CTRL, rd_v);
      chk(rd_v, {res, pol, i[3], i[2:0]});
      if (pin_sel[0]) chk({6'h0, pin_out}, {6'h0, res});
    end
    wr(ADDR_CTRL, 8'h3D);
    settle(10);
    @(posedge CLOCK);
    RESET_N <= 1'b0;
    repeat (3) @(posedge CLOCK);
    RESET_N <= 1'b1;
    settle(5);
    rd(ADDR_CTRL, rd_v);
    chk(rd_v, 8'h00);
    chk(route1, 8'h00);
    chk(route2, 8'h00);
    chk({4'h0, pin_sel, pin_out}, 8'h00);
    wr(ADDR_CTRL, 8'h02);
    wr(ADDR_MASK, 8'h01);
    settle(10);
    rd(ADDR_CTRL, rd_v);
    wr(ADDR_STATUS, 8'h01);
    settle(8);
    chk({7'h0, IRQ}, 8'h00);
    {volts[5], volts[6]} = {volts[6], volts[5]};
    settle(10);
    chk({7'h0, IRQ}, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, rd_v);
    chk(rd_v, 8'h01);
    rd(ADDR_CTRL, rd_v);
    wr(ADDR_STATUS, 8'h01);
    settle(3);
    rd(ADDR_STATUS, rd_v);
    chk({rd_v[0], IRQ}, 8'h00);
    wr(ADDR_MASK, 8'h00);
    {volts[5], volts[6]} = {volts[6], volts[5]};
    settle(10);
    rd(ADDR_STATUS, rd_v);
    chk({rd_v[0], IRQ}, 8'h02);
    close_out();
  end
endmodule
